// >>> rtl/ivt_cfg.svh
`ifndef IVT_CFG_SVH
`define IVT_CFG_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define IVT_CNT_W 16
`define IVT_SCALE_W 8
`define IVT_ADDR_W 4
`define IVT_DATA_W 32
`define IVT_BE_W 4
`define IVT_BYTE_W 8

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define IVT_OFS_COUNT 4'h0
`define IVT_OFS_SCALE 4'h4
`define IVT_OFS_PERIOD 4'h8
`define IVT_OFS_CTRL 4'hc

// ----------------------------------------------------------------
// Control and status field positions
// ----------------------------------------------------------------
`define IVT_CTRL_EN_BIT 0
`define IVT_CTRL_ZERO_BIT 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define IVT_RST_COUNT 16'h0000
`define IVT_RST_SCALE 8'h00
`define IVT_RST_PERIOD 16'h0000
`define IVT_RST_EN 1'b0
`define IVT_RST_RDATA 32'h0000_0000

`endif

// >>> rtl/ivt_core_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "ivt_cfg.svh"

interface ivt_core_if #(
    parameter int CNT_W = `IVT_CNT_W,
    parameter int SCALE_W = `IVT_SCALE_W
);
    logic enable;
    logic load;
    logic [CNT_W-1:0] load_value;
    logic [CNT_W-1:0] period;
    logic [SCALE_W-1:0] scale;
    logic [CNT_W-1:0] count;
    logic tick;
    logic zero_evt;

    modport ctl (
        output enable, load, load_value, period, scale,
        input count, tick, zero_evt
    );
    modport core (
        input enable, load, load_value, period, scale,
        output count, tick, zero_evt
    );
endinterface

`default_nettype wire

// >>> rtl/ivt_count_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "ivt_cfg.svh"

module ivt_count_core #(
    parameter int CNT_W = `IVT_CNT_W,
    parameter int SCALE_W = `IVT_SCALE_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    ivt_core_if.core cif
);

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    if (CNT_W < 2 || CNT_W > 32 || SCALE_W < 1 || SCALE_W > 32) begin : g_bad
        $error("ivt_count_core: unsupported width");
    end

    logic [SCALE_W-1:0] pre_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic evt_ff;
    logic tick_w;
    logic cnt_zero_w;

    assign tick_w = cif.enable && (pre_ff == '0);
    assign cnt_zero_w = (cnt_ff == '0);

    // ----------------------------------------------------------------
    // Prescaler: one tick every scale+1 cycles, held while ce is low, reloaded from scale while enable is low
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pre_ff <= SCALE_W'(`IVT_RST_SCALE);
        end else if (ce) begin
            if (!cif.enable || tick_w) begin
                pre_ff <= cif.scale; // R02
            end else begin
                pre_ff <= pre_ff - 1'b1; // R05
            end
        end
    end

    // ----------------------------------------------------------------
    // Down-counter with reload
    // ----------------------------------------------------------------
    always_comb begin
        if (cif.load) begin
            nxt_cnt = cif.load_value; // R07
        end else if (tick_w && cnt_zero_w) begin
            nxt_cnt = cif.period; // R04
        end else if (tick_w) begin
            nxt_cnt = cnt_ff - 1'b1; // R01
        end else begin
            nxt_cnt = cnt_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_ff <= CNT_W'(`IVT_RST_COUNT);
        end else if (ce) begin
            cnt_ff <= nxt_cnt;
        end
    end

    // ----------------------------------------------------------------
    // Zero event
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            evt_ff <= 1'b0;
        end else if (ce) begin
            evt_ff <= tick_w && cnt_zero_w; // R03
        end
    end

    assign cif.count = cnt_ff;
    assign cif.tick = tick_w;
    assign cif.zero_evt = evt_ff;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_dec;
        @(posedge clk) disable iff (!rst_n)
        ce && tick_w && !cnt_zero_w && !cif.load |=> cnt_ff == $past(cnt_ff) - 1'b1;
    endproperty
    a_dec: assert property (p_dec) else $error("count did not decrement"); // R01

    property p_pre_reload;
        @(posedge clk) disable iff (!rst_n)
        ce && tick_w |=> pre_ff == $past(cif.scale);
    endproperty
    a_pre_reload: assert property (p_pre_reload) else $error("prescaler not reloaded"); // R02

    property p_zero_evt;
        @(posedge clk) disable iff (!rst_n)
        ce && tick_w && cnt_zero_w |=> evt_ff;
    endproperty
    a_zero_evt: assert property (p_zero_evt) else $error("no zero event"); // R03

    property p_reload;
        @(posedge clk) disable iff (!rst_n)
        ce && tick_w && cnt_zero_w && !cif.load |=> cnt_ff == $past(cif.period);
    endproperty
    a_reload: assert property (p_reload) else $error("count not reloaded"); // R04

    property p_no_stall;
        @(posedge clk) disable iff (!rst_n)
        ce && cif.enable && !tick_w |=> pre_ff == $past(pre_ff) - 1'b1;
    endproperty
    a_no_stall: assert property (p_no_stall) else $error("prescaler stalled"); // R05

endmodule // ivt_count_core

`default_nettype wire

// >>> rtl/ivt_pkg.sv
`default_nettype none

package ivt_pkg;

    // Bus answer states, Gray coded along idle -> ack -> idle
    typedef enum logic [1:0] {
        IVT_IDLE = 2'b00,
        IVT_ACK = 2'b01
    } ivt_bus_state_e;

endpackage

`default_nettype wire

// >>> rtl/ivt_timer.sv
// Summary of operation
// R01: 16-bit counter decrements once every n cycles
// R02: 8-bit software prescale register sets n
// R03: Counter reaching zero raises timer interrupt
// R04: At zero, reload counter from period register
// R05: Timer runs concurrently, never stalls processor
// R06: Interrupt presented as internal interrupt source
// R07: Written count continues at current scaled rate
`timescale 1ns/1ps
`default_nettype none
`include "ivt_cfg.svh"

module ivt_timer #(
    parameter int CNT_W = `IVT_CNT_W,
    parameter int SCALE_W = `IVT_SCALE_W
) (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic CLK_EN,
    input wire logic [`IVT_ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [`IVT_DATA_W-1:0] AVS_WRITEDATA,
    input wire logic [`IVT_BE_W-1:0] AVS_BYTEENABLE,
    output logic [`IVT_DATA_W-1:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic TIMER_IRQ
);

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    if (CNT_W < 2 || CNT_W > `IVT_DATA_W ||
            SCALE_W < 1 || SCALE_W > `IVT_DATA_W) begin : g_bad
        $error("ivt_timer: unsupported width");
    end

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    ivt_pkg::ivt_bus_state_e state_ff;
    logic wait_ff;
    logic [`IVT_DATA_W-1:0] rdata_ff;
    logic [`IVT_DATA_W-1:0] rd_mux;
    logic [SCALE_W-1:0] scale_ff;
    logic [CNT_W-1:0] period_ff;
    logic en_ff;
    logic req_w;
    logic wr_acc_w;
    logic [`IVT_DATA_W-1:0] cnt_ext_w;
    logic [`IVT_DATA_W-1:0] scale_ext_w;
    logic [`IVT_DATA_W-1:0] period_ext_w;
    logic [`IVT_DATA_W-1:0] ctrl_ext_w;
    logic [`IVT_DATA_W-1:0] wr_cnt_w;
    logic [`IVT_DATA_W-1:0] wr_scale_w;
    logic [`IVT_DATA_W-1:0] wr_period_w;
    logic [`IVT_DATA_W-1:0] wr_ctrl_w;

    ivt_core_if #(.CNT_W(CNT_W), .SCALE_W(SCALE_W)) cif ();

    // ----------------------------------------------------------------
    // Byte-lane merge
    // ----------------------------------------------------------------
    function automatic logic [`IVT_DATA_W-1:0] be_merge(
        input logic [`IVT_DATA_W-1:0] old_val,
        input logic [`IVT_DATA_W-1:0] wdata,
        input logic [`IVT_BE_W-1:0] be
    );
        logic [`IVT_DATA_W-1:0] res;
        res = old_val;
        for (int i = 0; i < `IVT_BE_W; i++) begin
            if (be[i]) begin
                res[i*`IVT_BYTE_W +: `IVT_BYTE_W] = wdata[i*`IVT_BYTE_W +: `IVT_BYTE_W];
            end
        end
        return res;
    endfunction

    // ----------------------------------------------------------------
    // Register views, zero extended
    // ----------------------------------------------------------------
    always_comb begin
        cnt_ext_w = `IVT_DATA_W'(cif.count);
        scale_ext_w = `IVT_DATA_W'(scale_ff);
        period_ext_w = `IVT_DATA_W'(period_ff);
        ctrl_ext_w = '0;
        ctrl_ext_w[`IVT_CTRL_EN_BIT] = en_ff;
        ctrl_ext_w[`IVT_CTRL_ZERO_BIT] = (cif.count == '0);
    end

    always_comb begin
        wr_cnt_w = be_merge(cnt_ext_w, AVS_WRITEDATA, AVS_BYTEENABLE);
        wr_scale_w = be_merge(scale_ext_w, AVS_WRITEDATA, AVS_BYTEENABLE);
        wr_period_w = be_merge(period_ext_w, AVS_WRITEDATA, AVS_BYTEENABLE);
        wr_ctrl_w = be_merge(ctrl_ext_w, AVS_WRITEDATA, AVS_BYTEENABLE);
    end

    // ----------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------
    assign req_w = AVS_READ || AVS_WRITE;
    assign wr_acc_w = (state_ff == ivt_pkg::IVT_ACK) && AVS_WRITE;

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            state_ff <= ivt_pkg::IVT_IDLE;
            wait_ff <= 1'b1;
        end else if (CLK_EN) begin
            case (state_ff)
                ivt_pkg::IVT_IDLE: begin
                    if (req_w) begin
                        state_ff <= ivt_pkg::IVT_ACK;
                        wait_ff <= 1'b0;
                    end
                end
                ivt_pkg::IVT_ACK: begin
                    state_ff <= ivt_pkg::IVT_IDLE;
                    wait_ff <= 1'b1;
                end
                default: begin
                    state_ff <= ivt_pkg::IVT_IDLE;
                    wait_ff <= 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Read decode
    // ----------------------------------------------------------------
    always_comb begin
        if (AVS_ADDRESS == `IVT_OFS_COUNT) begin
            rd_mux = cnt_ext_w;
        end else if (AVS_ADDRESS == `IVT_OFS_SCALE) begin
            rd_mux = scale_ext_w;
        end else if (AVS_ADDRESS == `IVT_OFS_PERIOD) begin
            rd_mux = period_ext_w;
        end else if (AVS_ADDRESS == `IVT_OFS_CTRL) begin
            rd_mux = ctrl_ext_w;
        end else begin
            rd_mux = `IVT_RST_RDATA;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            rdata_ff <= `IVT_RST_RDATA;
        end else if (CLK_EN && state_ff == ivt_pkg::IVT_IDLE && AVS_READ) begin
            rdata_ff <= rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // Writable registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            scale_ff <= SCALE_W'(`IVT_RST_SCALE);
        end else if (CLK_EN && wr_acc_w && AVS_ADDRESS == `IVT_OFS_SCALE) begin
            scale_ff <= wr_scale_w[SCALE_W-1:0]; // R02
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            period_ff <= CNT_W'(`IVT_RST_PERIOD);
        end else if (CLK_EN && wr_acc_w && AVS_ADDRESS == `IVT_OFS_PERIOD) begin
            period_ff <= wr_period_w[CNT_W-1:0]; // R04
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            en_ff <= `IVT_RST_EN;
        end else if (CLK_EN && wr_acc_w && AVS_ADDRESS == `IVT_OFS_CTRL) begin
            en_ff <= wr_ctrl_w[`IVT_CTRL_EN_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Counter core
    // ----------------------------------------------------------------
    assign cif.enable = en_ff;
    assign cif.scale = scale_ff;
    assign cif.period = period_ff;
    assign cif.load = wr_acc_w && (AVS_ADDRESS == `IVT_OFS_COUNT); // R07
    assign cif.load_value = wr_cnt_w[CNT_W-1:0];

    ivt_count_core #(
        .CNT_W(CNT_W),
        .SCALE_W(SCALE_W)
    ) u_core (
        .clk(CLK_SYS),
        .rst_n(RESET_N),
        .ce(CLK_EN),
        .cif(cif)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign AVS_READDATA = rdata_ff;
    assign AVS_WAITREQUEST = wait_ff;
    assign TIMER_IRQ = cif.zero_evt; // R06

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_req_seen;
        CLK_EN && state_ff == ivt_pkg::IVT_IDLE && req_w;
    endsequence

    sequence s_ack_then_release;
        !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
    endsequence

    property p_bus_answer;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        s_req_seen ##1 CLK_EN |-> s_ack_then_release;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing wrong"); // R02

    property p_wait_idle;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        state_ff == ivt_pkg::IVT_IDLE |-> AVS_WAITREQUEST;
    endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("waitrequest low while idle"); // R02

    property p_read_data;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        CLK_EN && state_ff == ivt_pkg::IVT_IDLE && AVS_READ |=> AVS_READDATA == $past(rd_mux);
    endproperty
    a_read_data: assert property (p_read_data) else $error("read data not captured"); // R02

    property p_scale_write;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        CLK_EN && wr_acc_w && AVS_ADDRESS == `IVT_OFS_SCALE
        |=> scale_ff == $past(wr_scale_w[SCALE_W-1:0]);
    endproperty
    a_scale_write: assert property (p_scale_write) else $error("prescale write lost"); // R02

    property p_count_write;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        CLK_EN && cif.load |=> cif.count == $past(wr_cnt_w[CNT_W-1:0]);
    endproperty
    a_count_write: assert property (p_count_write) else $error("count write lost"); // R07

    sequence s_zero_tick;
        CLK_EN && cif.tick && cif.count == '0;
    endsequence

    property p_irq;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        s_zero_tick |=> TIMER_IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("timer interrupt missing"); // R06

    property p_irq_cause;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        CLK_EN && !(cif.tick && cif.count == '0) |=> !TIMER_IRQ;
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("spurious interrupt"); // R03

    property p_period_write;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        CLK_EN && wr_acc_w && AVS_ADDRESS == `IVT_OFS_PERIOD
        |=> period_ff == $past(wr_period_w[CNT_W-1:0]);
    endproperty
    a_period_write: assert property (p_period_write) else $error("period write lost"); // R04

    property p_run_during_bus;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        CLK_EN && en_ff && req_w && cif.tick && cif.count != '0 && !cif.load
        |=> cif.count == $past(cif.count) - 1'b1;
    endproperty
    a_run_during_bus: assert property (p_run_during_bus) else $error("timer stalled by bus"); // R05

endmodule // ivt_timer

`default_nettype wire

// >>> tb/ivt_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "ivt_cfg.svh"

`define CHK(what, exp, got) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
        end \
    end

module ivt_timer_test;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic timer_irq;
    int mismatches = 0;
    int checks_done = 0;
    int unsigned cyc = 0;
    int unsigned irq_times[$];
    logic [31:0] shadow [0:15];
    logic [3:0] addr_tab [0:4] = '{`IVT_OFS_COUNT, `IVT_OFS_SCALE, `IVT_OFS_PERIOD, 4'h6, 4'h2};

    // ----------------------------------------------------------------
    // Device, clock and monitors
    // ----------------------------------------------------------------
    ivt_timer i_dut (
        .CLK_SYS(clk_sys),
        .RESET_N(reset_n),
        .CLK_EN(clk_en),
        .AVS_ADDRESS(avs_address),
        .AVS_READ(avs_read),
        .AVS_WRITE(avs_write),
        .AVS_WRITEDATA(avs_writedata),
        .AVS_BYTEENABLE(avs_byteenable),
        .AVS_READDATA(avs_readdata),
        .AVS_WAITREQUEST(avs_waitrequest),
        .TIMER_IRQ(timer_irq)
    );

    initial begin
        forever #10 clk_sys = ~clk_sys;
    end

    always_ff @(posedge clk_sys) begin
        cyc <= cyc + 1;
    end

    always @(posedge clk_sys) begin
        if (timer_irq === 1'b1) begin
            irq_times.push_back(cyc);
        end
    end

    // ----------------------------------------------------------------
    // Expectation helpers and bus tasks
    // ----------------------------------------------------------------
    function automatic logic [31:0] reg_mask(input logic [3:0] a);
        case (a)
            `IVT_OFS_COUNT, `IVT_OFS_PERIOD: return 32'h0000_ffff;
            `IVT_OFS_SCALE: return 32'h0000_00ff;
            default: return 32'h0000_0000;
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction

    task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                            input logic [3:0] be, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        `CHK("bus answer", 1'b0, avs_waitrequest)
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] rd;
        bus_xfer(1'b1, a, d, be, rd);
        shadow[a] = merge(shadow[a], d, be) & reg_mask(a);
    endtask

    task automatic rd_chk(input logic [3:0] a);
        logic [31:0] rd;
        bus_xfer(1'b0, a, 32'h0000_0000, 4'h0, rd);
        `CHK("register read", shadow[a], rd)
    endtask

    task automatic run_period(input logic [7:0] p, input logic [15:0] per);
        logic [31:0] rd;
        int n;
        int unsigned span;
        n = 0;
        span = (int'(per) + 1) * (int'(p) + 1);
        bus_xfer(1'b1, `IVT_OFS_CTRL, 32'h0000_0000, 4'h1, rd);
        wr_reg(`IVT_OFS_SCALE, {24'h000000, p}, 4'h1);
        wr_reg(`IVT_OFS_PERIOD, {16'h0000, per}, 4'h3);
        wr_reg(`IVT_OFS_COUNT, 32'h0000_0000, 4'h3);
        irq_times.delete();
        bus_xfer(1'b1, `IVT_OFS_CTRL, 32'h0000_0001, 4'h1, rd);
        while (irq_times.size() < 3 && n < 3 * span + 40) begin
            @(posedge clk_sys);
            n++;
        end
        `CHK("irq seen", 1'b1, irq_times.size() >= 3)
        if (irq_times.size() >= 3) begin
            `CHK("irq spacing", span, irq_times[1] - irq_times[0])
            `CHK("irq spacing", span, irq_times[2] - irq_times[1])
        end
        bus_xfer(1'b1, `IVT_OFS_CTRL, 32'h0000_0000, 4'h1, rd);
    endtask

    task automatic print_verdict();
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (60000) @(posedge clk_sys);
        mismatches++;
        print_verdict();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] rd;
        logic [3:0] a;
        int unsigned t0;
        int n;
        rd = $urandom(32'he8b6);
        for (int i = 0; i < 16; i++) begin
            shadow[i] = 32'h0000_0000;
        end
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        // Reset values and register access
        for (int i = 0; i < 5; i++) begin
            rd_chk(addr_tab[i]);
        end
        wr_reg(`IVT_OFS_COUNT, 32'hffff_ffff, 4'hf);
        rd_chk(`IVT_OFS_COUNT);
        for (int i = 0; i < 14; i++) begin
            a = addr_tab[$urandom_range(0, 4)];
            wr_reg(a, $urandom, 4'($urandom_range(0, 15)));
            rd_chk(a);
        end
        // Zero status bit is read-only and follows the count
        wr_reg(`IVT_OFS_COUNT, 32'h0000_0000, 4'h3);
        bus_xfer(1'b0, `IVT_OFS_CTRL, 32'h0000_0000, 4'h0, rd);
        `CHK("status zero", 32'h0000_0002, rd)
        bus_xfer(1'b1, `IVT_OFS_CTRL, 32'hffff_fffe, 4'hf, rd);
        wr_reg(`IVT_OFS_COUNT, 32'h0000_0005, 4'h3);
        bus_xfer(1'b0, `IVT_OFS_CTRL, 32'h0000_0000, 4'h0, rd);
        `CHK("status nonzero", 32'h0000_0000, rd)
        // Interrupt period at corner and random settings
        run_period(8'h00, 16'h0000);
        run_period(8'hff, 16'h0001);
        run_period(8'h02, 16'hffff - 16'hfff0);
        for (int i = 0; i < 4; i++) begin
            run_period(8'($urandom_range(0, 5)), 16'($urandom_range(0, 9)));
        end
        // Count written while running continues from the new value
        wr_reg(`IVT_OFS_SCALE, 32'h0000_0000, 4'h1);
        wr_reg(`IVT_OFS_PERIOD, 32'h0000_00ff, 4'h3);
        wr_reg(`IVT_OFS_COUNT, 32'h0000_0200, 4'h3);
        bus_xfer(1'b1, `IVT_OFS_CTRL, 32'h0000_0001, 4'h1, rd);
        repeat (5) @(posedge clk_sys);
        irq_times.delete();
        bus_xfer(1'b1, `IVT_OFS_COUNT, 32'h0000_0014, 4'h3, rd);
        t0 = cyc;
        n = 0;
        while (irq_times.size() < 1 && n < 100) begin
            @(posedge clk_sys);
            n++;
        end
        `CHK("irq after count write", 1'b1, irq_times.size() >= 1)
        if (irq_times.size() >= 1) begin
            `CHK("cycles to irq", 32'd22, irq_times[0] - t0)
        end
        // Clock enable low freezes the timer between two interrupts
        irq_times.delete();
        n = 0;
        while (irq_times.size() < 1 && n < 600) begin
            @(posedge clk_sys);
            n++;
        end
        clk_en <= 1'b0;
        repeat (7) @(posedge clk_sys);
        clk_en <= 1'b1;
        n = 0;
        while (irq_times.size() < 2 && n < 600) begin
            @(posedge clk_sys);
            n++;
        end
        `CHK("irq after freeze", 1'b1, irq_times.size() >= 2)
        if (irq_times.size() >= 2) begin
            `CHK("irq spacing with freeze", 32'd256 + 32'd7, irq_times[1] - irq_times[0])
        end
        // Reset in mid-run clears every register and stops the timer
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            shadow[addr_tab[i]] = 32'h0000_0000;
            rd_chk(addr_tab[i]);
        end
        bus_xfer(1'b0, `IVT_OFS_CTRL, 32'h0000_0000, 4'h0, rd);
        `CHK("control after reset", 32'h0000_0002, rd)
        bus_xfer(1'b1, `IVT_OFS_CTRL, 32'h0000_0000, 4'h1, rd);
        print_verdict();
    end
endmodule // ivt_timer_test

`default_nettype wire
